// ==== design/fcdp_pkg.sv ====
// Purpose: Shared constants and types for the flexible converter data port
// Assumes: 32-bit APB register bus, 10-bit converter words
// Notes:   Register fields are carried as packed structs
package fcdp_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int DATA_W = 10;
	localparam int APB_W  = 32;

	// ************************************************************
	// Interface modes, Gray coded along the mode list
	// ************************************************************
	typedef enum logic [1:0] {
		full_duplex_mode             = 2'h0,
		half_duplex_interleaved_mode = 2'h1,
		half_duplex_parallel_mode    = 2'h3,
		clone_mode                   = 2'h2
	} fcdp_mode_type;

	// ************************************************************
	// Interpolation codes
	// ************************************************************
	localparam logic [1:0] INTERP_1X  = 2'h0;
	localparam logic [1:0] INTERP_2X  = 2'h1;
	localparam logic [1:0] INTERP_4X  = 2'h2;

	// ************************************************************
	// Register byte offsets and reset values
	// ************************************************************
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_RX_DIV = 8'h04;
	localparam logic [7:0] OFS_TX_DIV = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [7:0] DIV_RESET  = 8'h02;
	localparam logic [7:0] DIV_MIN    = 8'h02;

	// Control register, bit 0 upward: reg_en, mode, interp, sysclk_en
	typedef struct packed {
		logic          sysclk_en;
		logic [1:0]    interp;
		fcdp_mode_type mode;
		logic          reg_en;
	} fcdp_ctrl_type;

	// Status register, top bit first
	typedef struct packed {
		logic [1:0]    strap_interp;
		logic          strap_half_duplex_interleaved_mode;
		logic          strap_fd;
		logic          interp_bad;
		logic          tx_pd;
		logic          rx_pd;
		logic          dir_tx;
		logic [1:0]    interp;
		logic          reg_en;
		fcdp_mode_type mode;
	} fcdp_status_type;

	// Whole state of the port
	typedef struct packed {
		logic              strap_done;
		logic              strap_fd;
		logic              strap_half_duplex_interleaved_mode;
		logic [1:0]        strap_interp;
		fcdp_ctrl_type     ctrl;
		logic [7:0]        rx_div;
		logic [7:0]        tx_div;
		logic              pready;
		logic              pslverr;
		logic [APB_W-1:0]  prdata;
		logic              sys_phase;
		logic              rx_phase;
		logic              rx_sync;
		logic              rx_clk;
		logic              rx_sample;
		logic [DATA_W-1:0] rx_word;
		logic [DATA_W-1:0] rx_hold_b;
		logic [DATA_W-1:0] upper_out;
		logic [DATA_W-1:0] upper_oe_n;
		logic [DATA_W-1:0] lower_out;
		logic [DATA_W-1:0] lower_oe_n;
		logic              pin_two_out;
		logic              pin_two_oe_n;
		logic              pin_three;
		logic              tx_clk;
		logic              tx_a_seen;
		logic [DATA_W-1:0] tx_hold_a;
		logic [DATA_W-1:0] tx_out_a;
		logic [DATA_W-1:0] tx_out_b;
		logic              tx_valid;
	} fcdp_state_type;

endpackage : fcdp_pkg

// ==== design/fcdp_rate_divider.sv ====
// Purpose: Divides the master clock into a one-cycle strobe
// Assumes: i_divide of at least two; smaller values act as one
// Notes:   Counter restarts whenever i_enable is low
`timescale 1ns/100ps
module fcdp_rate_divider #(
	parameter int WIDTH = 8
) (
	input  wire logic             i_mclk,    // Master clock
	input  wire logic             i_reset_n, // Sync reset, active low
	input  wire logic             i_enable,  // Run the divider
	input  wire logic [WIDTH-1:0] i_divide,  // Cycles per strobe
	output logic                  o_strobe   // One-cycle strobe
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (WIDTH < 2 || WIDTH > 16) begin : g_bad_width
		$error("fcdp_rate_divider: WIDTH out of range");
	end

	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic             strobe;
	} fcdp_div_state_type;

	fcdp_div_state_type state;
	fcdp_div_state_type next_state;
	logic [WIDTH-1:0]   last;

	// Terminal count, never below zero
	assign last = (i_divide == '0) ? '0 : i_divide - 1'b1;

	// Count and strobe
	always_comb begin
		next_state = state;
		next_state.strobe = 1'b0;
		if (!i_enable) begin
			next_state.count = '0;
		end else if (state.count >= last) begin
			next_state.count  = '0;
			next_state.strobe = 1'b1;
		end else begin
			next_state.count = state.count + 1'b1;
		end
	end

	// State register
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign o_strobe = state.strobe;

endmodule : fcdp_rate_divider

// ==== design/fcdp_data_port.sv ====
// Purpose: Flexible 20-pin converter data port with APB configuration
// Assumes: Pins synchronous to i_mclk; converters sample on o_rx_sample
// Notes:   Output enables are active low; bus clocks are strobe pulses
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/100ps

module fcdp_data_port #(
	parameter int ADDR_W = 8,
	parameter int DIV_W  = 8
) (
	input  wire logic                       i_mclk,           // 20 MHz clock
	input  wire logic                       i_reset_n,        // Sync reset
	input  wire logic                       i_psel,           // APB select
	input  wire logic                       i_penable,        // APB enable
	input  wire logic                       i_pwrite,         // APB write
	input  wire logic [ADDR_W-1:0]          i_paddr,          // APB address
	input  wire logic [31:0]                i_pwdata,         // APB wdata
	input  wire logic [3:0]                 i_pstrb,          // APB lanes
	output logic [31:0]                     o_prdata,         // APB rdata
	output logic                            o_pready,         // APB ready
	output logic                            o_pslverr,        // APB error
	input  wire logic                       i_strap_full_duplex, // FD strap
	input  wire logic [1:0]                 i_strap_interp,   // Interp strap
	input  wire logic                       i_receive_powerdown_pin,  // Rx pd
	input  wire logic                       i_transmit_powerdown_pin, // Tx pd
	input  wire logic [fcdp_pkg::DATA_W-1:0] i_upper_bus,     // Upper in
	output logic [fcdp_pkg::DATA_W-1:0]     o_upper_bus,      // Upper out
	output logic [fcdp_pkg::DATA_W-1:0]     o_upper_bus_oe_n, // Upper oe_n
	input  wire logic [fcdp_pkg::DATA_W-1:0] i_lower_bus,     // Lower in
	output logic [fcdp_pkg::DATA_W-1:0]     o_lower_bus,      // Lower out
	output logic [fcdp_pkg::DATA_W-1:0]     o_lower_bus_oe_n, // Lower oe_n
	input  wire logic                       i_iface_pin_one,  // Sync or dir
	input  wire logic                       i_iface_pin_two,  // Pin two in
	output logic                            o_iface_pin_two,  // Pin two out
	output logic                            o_iface_pin_two_oe_n, // oe_n
	output logic                            o_iface_pin_three, // Bus clock
	input  wire logic [fcdp_pkg::DATA_W-1:0] i_rx_chan_a,     // Rx conv A
	input  wire logic [fcdp_pkg::DATA_W-1:0] i_rx_chan_b,     // Rx conv B
	output logic                            o_rx_sample,      // Conv sample
	output logic [fcdp_pkg::DATA_W-1:0]     o_tx_chan_a,      // Tx word A
	output logic [fcdp_pkg::DATA_W-1:0]     o_tx_chan_b,      // Tx word B
	output logic                            o_tx_valid        // Tx pair pulse
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
		$error("fcdp_data_port: ADDR_W out of range");
	end
	if (DIV_W != 8) begin : g_bad_div
		$error("fcdp_data_port: DIV_W must match the divider registers");
	end

	fcdp_pkg::fcdp_state_type  state;
	fcdp_pkg::fcdp_state_type  next_state;
	fcdp_pkg::fcdp_mode_type   mode_eff;
	fcdp_pkg::fcdp_status_type status;
	logic [1:0]                interp_eff;
	logic                      interp_ok;
	logic                      full;
	logic                      dir_tx;
	logic                      rx_active;
	logic                      tx_active;
	logic                      rx_interleaved;
	logic                      rx_strobe;
	logic                      tx_strobe;
	logic [DIV_W-1:0]          rx_div_eff;
	logic [DIV_W-1:0]          tx_div_eff;
	logic [7:0]                addr;
	logic                      apb_setup;
	logic                      apb_write;
	logic                      rd_hit;
	logic [31:0]               rd_data;
	logic                      tx_sync;

	// ************************************************************
	// Mode selection
	// ************************************************************
	// Straps never yield clone mode; registers may
	always_comb begin
		if (state.ctrl.reg_en) begin
			mode_eff   = state.ctrl.mode;
			interp_eff = state.ctrl.interp;
		end else begin
			if (state.strap_fd) begin
				mode_eff = fcdp_pkg::full_duplex_mode;
			end else if (state.strap_half_duplex_interleaved_mode) begin
				mode_eff = fcdp_pkg::half_duplex_interleaved_mode;
			end else begin
				mode_eff = fcdp_pkg::half_duplex_parallel_mode;
			end
			interp_eff = state.strap_interp;
		end
	end

	// Interleaved modes need two or four times interpolation
	assign interp_ok = (interp_eff == fcdp_pkg::INTERP_2X) ||
		(interp_eff == fcdp_pkg::INTERP_4X) ||
		((mode_eff == fcdp_pkg::half_duplex_parallel_mode) &&
		(interp_eff == fcdp_pkg::INTERP_1X));

	// Direction and path enables
	assign full      = (mode_eff == fcdp_pkg::full_duplex_mode);
	assign dir_tx    = i_iface_pin_one;
	assign rx_active = state.strap_done && !i_receive_powerdown_pin &&
		(full || !dir_tx);
	assign tx_active = state.strap_done && !i_transmit_powerdown_pin &&
		interp_ok && (full || dir_tx);
	assign rx_interleaved = full ||
		(mode_eff == fcdp_pkg::half_duplex_interleaved_mode);

	// ************************************************************
	// Rate dividers
	// ************************************************************
	// Divider values below the minimum act as the minimum
	assign rx_div_eff = (state.rx_div < fcdp_pkg::DIV_MIN) ?
		fcdp_pkg::DIV_MIN : state.rx_div;
	assign tx_div_eff = (state.tx_div < fcdp_pkg::DIV_MIN) ?
		fcdp_pkg::DIV_MIN : state.tx_div;

	// Receive word rate, programmable
	fcdp_rate_divider #(.WIDTH(DIV_W)) u_rx_div (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_enable  (rx_active),
		.i_divide  (rx_div_eff),
		.o_strobe  (rx_strobe)
	);

	// Transmit word rate
	fcdp_rate_divider #(.WIDTH(DIV_W)) u_tx_div (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_enable  (tx_active),
		.i_divide  (tx_div_eff),
		.o_strobe  (tx_strobe)
	);

	// ************************************************************
	// APB decode and read data
	// ************************************************************
	assign addr      = 8'(i_paddr);
	assign apb_setup = i_psel && !i_penable;
	assign apb_write = i_psel && i_penable && state.pready && i_pwrite &&
		i_pstrb[0];

	// Status view of the live configuration
	always_comb begin
		status.mode         = mode_eff;
		status.reg_en       = state.ctrl.reg_en;
		status.interp       = interp_eff;
		status.dir_tx       = dir_tx;
		status.rx_pd        = i_receive_powerdown_pin;
		status.tx_pd        = i_transmit_powerdown_pin;
		status.interp_bad   = !interp_ok;
		status.strap_fd     = state.strap_fd;
		status.strap_half_duplex_interleaved_mode   = state.strap_half_duplex_interleaved_mode;
		status.strap_interp = state.strap_interp;
	end

	// Read multiplexer; unmapped reads return zero with an error
	always_comb begin
		rd_hit  = 1'b1;
		rd_data = 32'h0000_0000;
		case (addr)
			fcdp_pkg::OFS_CTRL: begin
				rd_data = {26'h000_0000, state.ctrl};
			end
			fcdp_pkg::OFS_RX_DIV: begin
				rd_data = {24'h00_0000, state.rx_div};
			end
			fcdp_pkg::OFS_TX_DIV: begin
				rd_data = {24'h00_0000, state.tx_div};
			end
			fcdp_pkg::OFS_STATUS: begin
				rd_data = {19'h0_0000, status};
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// Sync source for interleaved transmit words
	assign tx_sync = full ? i_iface_pin_one : i_lower_bus[9];

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_state           = state;
		next_state.pready    = 1'b0;
		next_state.pslverr   = 1'b0;
		next_state.rx_sample = 1'b0;
		next_state.tx_valid  = 1'b0;
		next_state.sys_phase = ~state.sys_phase;

		// Catch straps in the first cycle after release
		if (!state.strap_done) begin
			next_state.strap_done   = 1'b1;
			next_state.strap_fd     = i_strap_full_duplex;
			next_state.strap_half_duplex_interleaved_mode   = i_iface_pin_two;
			next_state.strap_interp = i_strap_interp;
		end

		// Zero-wait APB answer prepared in the setup cycle
		if (apb_setup) begin
			next_state.pready  = 1'b1;
			next_state.prdata  = rd_data;
			next_state.pslverr = !rd_hit || (i_pwrite &&
				(addr == fcdp_pkg::OFS_STATUS));
		end
		if (apb_write) begin
			case (addr)
				fcdp_pkg::OFS_CTRL: begin
					next_state.ctrl = fcdp_pkg::fcdp_ctrl_type'(i_pwdata[5:0]);
				end
				fcdp_pkg::OFS_RX_DIV: begin
					next_state.rx_div = i_pwdata[7:0];
				end
				fcdp_pkg::OFS_TX_DIV: begin
					next_state.tx_div = i_pwdata[7:0];
				end
				default: begin
				end
			endcase
		end

		// Receive words: interleaved A then B, or both at once
		next_state.rx_clk = rx_strobe;
		if (rx_strobe) begin
			if (rx_interleaved) begin
				if (!state.rx_phase) begin
					next_state.rx_sample = 1'b1;
					next_state.rx_word   = i_rx_chan_a;
					next_state.rx_hold_b = i_rx_chan_b;
				end else begin
					next_state.rx_word = state.rx_hold_b;
				end
				next_state.rx_sync  = state.rx_phase;
				next_state.rx_phase = ~state.rx_phase;
			end else begin
				next_state.rx_sample = 1'b1;
				next_state.rx_word   = i_rx_chan_a;
				next_state.rx_hold_b = i_rx_chan_b;
				next_state.rx_phase  = 1'b0;
			end
		end

		// Bus directions; all pins listen unless driven
		next_state.upper_oe_n = '1;
		next_state.lower_oe_n = '1;
		case (mode_eff)
			fcdp_pkg::full_duplex_mode: begin
				next_state.lower_oe_n = '0;
				next_state.lower_out  = next_state.rx_word;
			end
			fcdp_pkg::half_duplex_interleaved_mode: begin
				if (!dir_tx) begin
					next_state.lower_oe_n = '0;
					next_state.lower_out  = next_state.rx_word;
					next_state.upper_oe_n = 10'h1ff;
					next_state.upper_out  = {next_state.rx_sync, 9'h000};
				end
			end
			fcdp_pkg::half_duplex_parallel_mode,
			fcdp_pkg::clone_mode: begin
				if (!dir_tx) begin
					next_state.upper_oe_n = '0;
					next_state.upper_out  = next_state.rx_hold_b;
					next_state.lower_oe_n = '0;
					next_state.lower_out  = next_state.rx_word;
				end
			end
			default: begin
			end
		endcase

		// Transmit words: pair by sync, or parallel
		next_state.tx_clk = tx_strobe;
		if (!tx_active) begin
			next_state.tx_a_seen = 1'b0;
		end else if (tx_strobe) begin
			if (mode_eff == fcdp_pkg::half_duplex_parallel_mode) begin
				next_state.tx_out_a = i_upper_bus;
				next_state.tx_out_b = i_lower_bus;
				next_state.tx_valid = 1'b1;
			end else if (tx_sync) begin
				next_state.tx_hold_a = i_upper_bus;
				next_state.tx_a_seen = 1'b1;
			end else if (state.tx_a_seen) begin
				next_state.tx_out_a  = state.tx_hold_a;
				next_state.tx_out_b  = i_upper_bus;
				next_state.tx_valid  = 1'b1;
				next_state.tx_a_seen = 1'b0;
			end
		end

		// Third pin: transmit clock in full duplex or tx direction
		next_state.pin_three = (full || dir_tx) ?
			next_state.tx_clk : next_state.rx_clk;

		// Second pin: system clock, channel flag, or input
		next_state.pin_two_oe_n = 1'b1;
		if (state.ctrl.reg_en) begin
			if (full || state.ctrl.sysclk_en) begin
				next_state.pin_two_oe_n = 1'b0;
				next_state.pin_two_out  = state.sys_phase;
			end
		end else if (full && state.strap_done) begin
			next_state.pin_two_oe_n = 1'b0;
			next_state.pin_two_out  = next_state.rx_sync;
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			state            <= '0;
			state.ctrl       <= fcdp_pkg::fcdp_ctrl_type'(fcdp_pkg::CTRL_RESET);
			state.rx_div     <= fcdp_pkg::DIV_RESET;
			state.tx_div     <= fcdp_pkg::DIV_RESET;
			state.upper_oe_n <= '1;
			state.lower_oe_n <= '1;
			state.pin_two_oe_n <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// Outputs straight from the state register
	assign o_prdata             = state.prdata;
	assign o_pready             = state.pready;
	assign o_pslverr            = state.pslverr;
	assign o_upper_bus          = state.upper_out;
	assign o_upper_bus_oe_n     = state.upper_oe_n;
	assign o_lower_bus          = state.lower_out;
	assign o_lower_bus_oe_n     = state.lower_oe_n;
	assign o_iface_pin_two      = state.pin_two_out;
	assign o_iface_pin_two_oe_n = state.pin_two_oe_n;
	assign o_iface_pin_three    = state.pin_three;
	assign o_rx_sample          = state.rx_sample;
	assign o_tx_chan_a          = state.tx_out_a;
	assign o_tx_chan_b          = state.tx_out_b;
	assign o_tx_valid           = state.tx_valid;

	// ************************************************************
	// Assertions
	// ************************************************************
	a_strap_latch: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		!state.strap_done |=> state.strap_half_duplex_interleaved_mode == $past(i_iface_pin_two) &&
		state.strap_fd == $past(i_strap_full_duplex))
		else $error("straps not caught at release");
	a_clone_regonly: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		!state.ctrl.reg_en |-> mode_eff != fcdp_pkg::clone_mode)
		else $error("clone mode without registers");
	a_fd_bus_dirs: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		full |=> o_lower_bus_oe_n == '0 && o_upper_bus_oe_n == '1)
		else $error("full duplex bus directions wrong");
	a_fd_rx_chan: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		full && !state.ctrl.reg_en && rx_strobe && !state.rx_phase |=>
		o_lower_bus == $past(i_rx_chan_a) && !o_iface_pin_two
		##1 o_lower_bus == $past(i_rx_chan_a, 2))
		else $error("channel A word or flag wrong");
	a_tx_clock: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		full && tx_strobe |=> o_iface_pin_three ##1 !o_iface_pin_three)
		else $error("transmit clock pulse missing");
	a_tx_steer: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		full && tx_active && tx_strobe && !i_iface_pin_one &&
		state.tx_a_seen |=> o_tx_valid && o_tx_chan_b == $past(i_upper_bus))
		else $error("channel B transmit word lost");
	a_half_duplex_interleaved_mode_tristate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		mode_eff == fcdp_pkg::half_duplex_interleaved_mode && !dir_tx |=>
		o_upper_bus_oe_n == 10'h1ff && o_lower_bus_oe_n == '0)
		else $error("unused bus not released");
	a_half_duplex_parallel_mode_tx_map: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		mode_eff == fcdp_pkg::half_duplex_parallel_mode && tx_active &&
		tx_strobe |=> o_tx_valid && o_tx_chan_a == $past(i_upper_bus) &&
		o_tx_chan_b == $past(i_lower_bus))
		else $error("parallel transmit mapping wrong");
	a_clone_rx_par: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		mode_eff == fcdp_pkg::clone_mode && !dir_tx && rx_strobe |=>
		o_upper_bus == $past(i_rx_chan_b) && o_lower_bus == $past(i_rx_chan_a))
		else $error("clone receive mapping wrong");
	a_rx_pd_halt: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		i_receive_powerdown_pin [*2] |=> !o_rx_sample)
		else $error("receive ran while powered down");
	a_interp_gate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		full && !interp_ok |=> !o_tx_valid)
		else $error("transmit ran with bad interpolation");
	a_sysclk_pin: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		state.ctrl.reg_en && full && $past(state.ctrl.reg_en && full) |=>
		!o_iface_pin_two_oe_n && o_iface_pin_two != $past(o_iface_pin_two))
		else $error("system clock not on pin two");

endmodule : fcdp_data_port

// ==== dv/fcdp_host_model.sv ====
// Purpose: Host that feeds interleaved transmit words
// Assumes: Words move on after each pin three pulse
// Notes:   Sync high marks the A word
`timescale 1ns/100ps
module fcdp_host_model (
	input  wire logic                        i_mclk,   // Master clock
	input  wire logic                        i_tx_clk, // Pin three
	output logic                             o_sync,   // Transmit sync
	output logic [fcdp_pkg::DATA_W-1:0]      o_word    // Upper bus word
);
	// Swap A and B after each transmit clock
	initial o_sync = 1'b1;
	always @(posedge i_mclk) begin
		if (i_tx_clk === 1'b1)
			o_sync <= ~o_sync;
	end
	assign o_word = o_sync ? 10'h155 : 10'h0aa;
endmodule : fcdp_host_model

// ==== dv/flexible_converter_data_port_tb_top.sv ====
// Purpose: Bench for the converter data port
// Assumes: Straps pick full duplex at 2x
// Notes:   Dividers stay at reset value 2
`timescale 1ns/100ps
module flexible_converter_data_port_tb_top;
	logic        i_mclk = 1'b0;
	logic        i_reset_n = 1'b0;
	logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, pd = 1'b0;
	logic        hd = 1'b0, dir = 1'b0, rdy, err, er, sync, p1, p2, p3;
	logic        smp, tv, p2oe, q;
	logic [9:0]  uoe, loe;
	logic [7:0]  pa = 8'h00;
	logic [31:0] pwd = 32'h0, prd, rd;
	logic [9:0]  ca = 10'h2c3, cb = 10'h13c, hw, up, lo, ta, tb;
	int          fails = 0, n_compared = 0;
	// Receive rate of mclk/2 stays within the limit
	// Clock and pin one steering
	always #25 i_mclk = ~i_mclk;
	assign p1 = hd ? dir : sync;
	fcdp_host_model host (.i_mclk(i_mclk), .i_tx_clk(p3), .o_sync(sync),
		.o_word(hw));
	fcdp_data_port uut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
		.i_pwdata(pwd), .i_pstrb(4'hf), .o_prdata(prd), .o_pready(rdy),
		.o_pslverr(err), .i_strap_full_duplex(1'b1), .i_strap_interp(2'h1),
		.i_receive_powerdown_pin(pd), .i_transmit_powerdown_pin(pd),
		.i_upper_bus(hw), .o_upper_bus(up), .o_upper_bus_oe_n(uoe),
		.i_lower_bus(10'h000), .o_lower_bus(lo), .o_lower_bus_oe_n(loe),
		.i_iface_pin_one(p1), .i_iface_pin_two(1'b1), .o_iface_pin_two(p2),
		.o_iface_pin_two_oe_n(p2oe), .o_iface_pin_three(p3), .i_rx_chan_a(ca),
		.i_rx_chan_b(cb), .o_rx_sample(smp), .o_tx_chan_a(ta),
		.o_tx_chan_b(tb), .o_tx_valid(tv));
	// Verdict and end of run
	task automatic conclude;
		$display("Compared %0d fails %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge i_mclk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge i_mclk);
		pen <= 1'b1;
		do begin
			@(posedge i_mclk);
			k++;
			if (k > 20) begin
				fails++;
				conclude();
			end
		end while (rdy !== 1'b1);
		rd = prd;
		er = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic wait_hi(ref logic s);
		int k;
		k = 0;
		#1;
		while (s !== 1'b1) begin
			@(posedge i_mclk);
			#1;
			k++;
			if (k > 100) begin
				fails++;
				conclude();
			end
		end
	endtask : wait_hi
	// Main sequence
	initial begin
		repeat (16) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		apb(1'b0, fcdp_pkg::OFS_STATUS, 32'h0);
		chk("status", 32'h0e08, rd & ~32'h20);
		wait_hi(smp);
		chk("rx a", ca, lo);
		chk("flag a", 32'h0, p2);
		chk("flag oe", 32'h0, p2oe);
		repeat (2) @(posedge i_mclk);
		#1;
		chk("rx b", cb, lo);
		chk("flag b", 32'h1, p2);
		wait_hi(tv);
		chk("tx a", 32'h155, ta);
		chk("tx b", 32'h0aa, tb);
		@(posedge i_mclk);
		pd <= 1'b1;
		repeat (3) @(posedge i_mclk);
		repeat (8) begin
			@(posedge i_mclk);
			#1;
			chk("rx halt", 32'h0, smp | tv);
		end
		@(posedge i_mclk);
		pd <= 1'b0;
		hd <= 1'b1;
		apb(1'b1, fcdp_pkg::OFS_CTRL, 32'h0d);
		apb(1'b0, fcdp_pkg::OFS_CTRL, 32'h0);
		chk("ctrl", 32'h0d, rd);
		wait_hi(smp);
		chk("clone up", cb, up);
		chk("clone lo", ca, lo);
		chk("clone oe", 32'h0, {uoe, loe});
		apb(1'b1, fcdp_pkg::OFS_CTRL, 32'h09);
		repeat (2) @(posedge i_mclk);
		#1;
		q = p2;
		chk("sys oe", 32'h0, p2oe);
		@(posedge i_mclk);
		#1;
		chk("sys clk", {31'h0, ~q}, p2);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h1, er);
		apb(1'b1, fcdp_pkg::OFS_STATUS, 32'h0);
		chk("ro write", 32'h1, er);
		conclude();
	end
endmodule : flexible_converter_data_port_tb_top
